// >>> src/acr_regbank.sv
// Control register bank of the delta-sigma converter: identity, power, link options, conversion mode
// Notes on behaviour
// - Identity register at offset zero: part code bits 7:5, revision bits 4:0, read only.
// - Reset flag sets on every reset, stays clear after host writes zero.
// - Power bit 1 enables level shift on the common input pin, resets off.
// - Power bit 0 enables internal reference, resets on; current sources need it.
// - Power register resets to 11h, reserved bits read zero.
// - Link bit 3 enables interface time-out, resets off.
// - Link bit 2 adds status byte to read-back, resets on.
// - Check field picks none, checksum, CRC; 11 reserved.
// - Link register resets to 05h, upper four bits read zero.
// - Mode bit 7 inverts reference polarity, default normal.
// - Mode bit 6 picks continuous or single-shot conversion.
// - Chop field: off, input chop, current rotation, both.
// - Delay field waits from start to conversion; codes above 1011 reserved.
// - Mode register resets to zero.
// - Mode write restarts primary conversion and drives data ready high.
// - Mode register is a group: update only when write command completes.
`timescale 1ns/10ps
module acr_regbank
    import acr_pkg::*;
#(
    parameter logic [2:0] PART_CODE = 3'h5, // Arbitrary value
    parameter logic [4:0] SILICON_REVISION = 5'h0A // Arbitrary value
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Register access from the serial command decoder
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic CMD_DONE,
    input wire logic CMD_ABORT,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // Power and interface controls
    output logic LEVEL_SHIFT_ENABLE,
    output logic INTERNAL_REFERENCE_ENABLE,
    output logic CURRENT_SOURCE_ALLOW,
    output logic TIMEOUT_ENABLE,
    output logic STATUS_BYTE_ENABLE,
    output logic [1:0] CHECK_MODE,
    // Primary converter controls
    output logic REFERENCE_POLARITY_INVERT,
    output logic CONVERSION_RUN_SELECT,
    output logic [1:0] CHOP_MODE,
    output logic [3:0] START_DELAY,
    output logic CONVERT_RESTART,
    output logic CONVERT_GO,
    output logic DATA_READY_OUT
);
    // ==========================================================
    // Storage
    logic [7:0] power_r;
    logic [7:0] link_r;
    logic [7:0] mode_r;
    logic [7:0] mode_pend_r;
    logic mode_pend_vld_r;
    logic restart_r;
    logic dly_busy;
    logic dly_done;

    // ==========================================================
    // Power register
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            power_r <= ACR_RST_POWER;
        end else if (REG_WR && REG_ADDR == ACR_OFS_POWER) begin
            power_r <= REG_WDATA & ACR_MASK_POWER;
            // Reset flag can only be cleared by the host, never set by a write; only reset sets it again
            power_r[ACR_POS_RESET_FLAG] <= REG_WDATA[ACR_POS_RESET_FLAG] & power_r[ACR_POS_RESET_FLAG];
        end
    end

    // ==========================================================
    // Serial link options register
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            link_r <= ACR_RST_LINK;
        end else if (REG_WR && REG_ADDR == ACR_OFS_LINK) begin
            link_r <= REG_WDATA & ACR_MASK_LINK;
        end
    end

    // ==========================================================
    // Conversion mode: buffered until the command completes
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mode_pend_r <= ACR_RST_MODE;
            mode_pend_vld_r <= 1'b0;
        end else if (CMD_ABORT) begin
            mode_pend_vld_r <= 1'b0;
        end else if (REG_WR && REG_ADDR == ACR_OFS_MODE) begin
            mode_pend_r <= REG_WDATA;
            mode_pend_vld_r <= 1'b1;
        end else if (CMD_DONE) begin
            mode_pend_vld_r <= 1'b0;
        end
    end

    // Commit on completion and flag a restart
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mode_r <= ACR_RST_MODE;
            restart_r <= 1'b0;
        end else if (CMD_DONE && !CMD_ABORT && mode_pend_vld_r) begin
            mode_r <= mode_pend_r;
            restart_r <= 1'b1;
        end else begin
            restart_r <= 1'b0;
        end
    end

    // ==========================================================
    // Start delay before the actual conversion
    acr_delay_timer #(
        .CNT_W(20)
    ) u_delay (
        .clk(CLK),
        .nrst(NRST),
        .start(restart_r),
        .code(mode_r[ACR_POS_DELAY +: 4]),
        .busy(dly_busy),
        .done(dly_done)
    );

    // Restart pulse, go pulse and data ready
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            CONVERT_RESTART <= 1'b0;
            CONVERT_GO <= 1'b0;
            DATA_READY_OUT <= 1'b1;
        end else begin
            CONVERT_RESTART <= restart_r;
            CONVERT_GO <= dly_done;
            if (restart_r || dly_busy) begin
                DATA_READY_OUT <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Read port
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            REG_RDATA <= 8'h00;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                unique case (REG_ADDR)
                    ACR_OFS_IDENTITY: REG_RDATA <= {PART_CODE, SILICON_REVISION};
                    ACR_OFS_POWER: REG_RDATA <= power_r;
                    ACR_OFS_LINK: REG_RDATA <= link_r;
                    ACR_OFS_MODE: REG_RDATA <= mode_r;
                    default: REG_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // ==========================================================
    // Control outputs
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            LEVEL_SHIFT_ENABLE <= 1'b0;
            INTERNAL_REFERENCE_ENABLE <= 1'b1;
            CURRENT_SOURCE_ALLOW <= 1'b1;
            TIMEOUT_ENABLE <= 1'b0;
            STATUS_BYTE_ENABLE <= 1'b1;
            CHECK_MODE <= ACR_CHK_SUM;
            REFERENCE_POLARITY_INVERT <= 1'b0;
            CONVERSION_RUN_SELECT <= 1'b0;
            CHOP_MODE <= ACR_CHOP_OFF;
            START_DELAY <= 4'h0;
        end else begin
            LEVEL_SHIFT_ENABLE <= power_r[ACR_POS_LEVEL_SHIFT];
            INTERNAL_REFERENCE_ENABLE <= power_r[ACR_POS_INT_REF];
            CURRENT_SOURCE_ALLOW <= power_r[ACR_POS_INT_REF];
            TIMEOUT_ENABLE <= link_r[ACR_POS_TIMEOUT];
            STATUS_BYTE_ENABLE <= link_r[ACR_POS_STATUS_BYTE];
            CHECK_MODE <= link_r[ACR_POS_CHECK +: 2];
            REFERENCE_POLARITY_INVERT <= mode_r[ACR_POS_POL_INV];
            CONVERSION_RUN_SELECT <= mode_r[ACR_POS_RUN_SEL];
            CHOP_MODE <= mode_r[ACR_POS_CHOP +: 2];
            START_DELAY <= mode_r[ACR_POS_DELAY +: 4];
        end
    end
endmodule // acr_regbank

// >>> src/acr_pkg.sv
// Package of offsets, field layouts, reset values and timing for the converter control register bank
package acr_pkg;
    // Register offsets
    localparam logic [7:0] ACR_OFS_IDENTITY = 8'h00;
    localparam logic [7:0] ACR_OFS_POWER = 8'h01;
    localparam logic [7:0] ACR_OFS_LINK = 8'h02;
    localparam logic [7:0] ACR_OFS_MODE = 8'h03;
    // Reset values
    localparam logic [7:0] ACR_RST_POWER = 8'h11;
    localparam logic [7:0] ACR_RST_LINK = 8'h05;
    localparam logic [7:0] ACR_RST_MODE = 8'h00;
    // Writable bit masks; all other bits read as zero
    localparam logic [7:0] ACR_MASK_POWER = 8'h13;
    localparam logic [7:0] ACR_MASK_LINK = 8'h0F;
    // Field positions
    localparam int ACR_POS_PART_CODE = 5;
    localparam int ACR_POS_RESET_FLAG = 4;
    localparam int ACR_POS_LEVEL_SHIFT = 1;
    localparam int ACR_POS_INT_REF = 0;
    localparam int ACR_POS_TIMEOUT = 3;
    localparam int ACR_POS_STATUS_BYTE = 2;
    localparam int ACR_POS_CHECK = 0;
    localparam int ACR_POS_POL_INV = 7;
    localparam int ACR_POS_RUN_SEL = 6;
    localparam int ACR_POS_CHOP = 4;
    localparam int ACR_POS_DELAY = 0;
    // Highest legal delay code
    localparam logic [3:0] ACR_DELAY_MAX = 4'hB;
    // Delay table in nanoseconds, code 0 to 11
    localparam int ACR_CLK_NS = 20;
    localparam int ACR_DELAY_NS [0:11] = '{0, 8700, 17000, 35000, 69000, 139000, 278000,
                                           555000, 1100000, 2200000, 4400000, 8800000};
    // Check byte modes
    typedef enum logic [1:0] {
        ACR_CHK_NONE = 2'b00,
        ACR_CHK_SUM = 2'b01,
        ACR_CHK_CRC = 2'b10,
        ACR_CHK_RSVD = 2'b11
    } acr_check_t;
    // Chop modes
    typedef enum logic [1:0] {
        ACR_CHOP_OFF = 2'b00,
        ACR_CHOP_INPUT = 2'b01,
        ACR_CHOP_ROTATE = 2'b10,
        ACR_CHOP_BOTH = 2'b11
    } acr_chop_t;
endpackage

// >>> src/acr_delay_timer.sv
// Start delay timer for the primary converter
`timescale 1ns/10ps
module acr_delay_timer
    import acr_pkg::*;
#(
    parameter int CNT_W = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic start,
    input wire logic [3:0] code,
    // Status
    output logic busy,
    output logic done
);
    logic [CNT_W-1:0] cnt_r;

    // Cycle count for a delay code, rounded down, at least one for any nonzero code, zero for code 0
    function automatic logic [CNT_W-1:0] delay_cycles(input logic [3:0] c);
        int n;
        n = (c > ACR_DELAY_MAX) ? 0 : ACR_DELAY_NS[c] / ACR_CLK_NS;
        if (c != 4'h0 && n < 1) begin
            n = 1;
        end
        return CNT_W'(n);
    endfunction

    // Load on start, count down to zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            cnt_r <= delay_cycles(code);
            busy <= 1'b1;
            done <= 1'b0;
        end else if (busy) begin
            if (cnt_r == '0) begin
                busy <= 1'b0;
                done <= 1'b1;
            end else begin
                cnt_r <= cnt_r - 1'b1;
            end
        end else begin
            done <= 1'b0;
        end
    end
endmodule // acr_delay_timer

// >>> tb/acr_regbank_assertions.sv
// Concurrent checks on the ports of the control register bank
`timescale 1ns/10ps
module acr_regbank_assertions
    import acr_pkg::*;
#(
    parameter logic [2:0] PART_CODE = 3'h5,
    parameter logic [4:0] SILICON_REVISION = 5'h0A
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Register access
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_RD,
    input wire logic CMD_DONE,
    input wire logic CMD_ABORT,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID,
    // Controls
    input wire logic INTERNAL_REFERENCE_ENABLE,
    input wire logic CURRENT_SOURCE_ALLOW,
    input wire logic CONVERT_RESTART,
    input wire logic DATA_READY_OUT
);
    // ==========
    // Properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    AST_RVALID: assert property (REG_RD |=> REG_RVALID) else $error("read not answered");
    AST_RVALID_CAUSE: assert property (REG_RVALID |-> $past(REG_RD)) else $error("stray read valid");
    AST_RDATA_HOLD: assert property (!REG_RVALID |-> $stable(REG_RDATA)) else $error("read data moved");
    AST_ID: assert property (REG_RD && REG_ADDR == ACR_OFS_IDENTITY |=>
        REG_RDATA == {PART_CODE, SILICON_REVISION}) else $error("identity wrong");
    AST_PWR_RSVD: assert property (REG_RD && REG_ADDR == ACR_OFS_POWER |=>
        (REG_RDATA & ~ACR_MASK_POWER) == 8'h00) else $error("power reserved set");
    AST_LINK_RSVD: assert property (REG_RD && REG_ADDR == ACR_OFS_LINK |=>
        (REG_RDATA & ~ACR_MASK_LINK) == 8'h00) else $error("link reserved set");
    AST_REF_GATE: assert property (CURRENT_SOURCE_ALLOW |-> INTERNAL_REFERENCE_ENABLE) else $error("no ref");
    AST_RST_READY: assert property (CONVERT_RESTART |-> DATA_READY_OUT) else $error("ready not high");
    AST_RST_PULSE: assert property (CONVERT_RESTART |=> !CONVERT_RESTART) else $error("restart too long");
    AST_RST_CAUSE: assert property (CONVERT_RESTART |->
        $past(CMD_DONE, 2) && !$past(CMD_ABORT, 2)) else $error("restart without commit");
endmodule // acr_regbank_assertions

bind acr_regbank acr_regbank_assertions #(.PART_CODE(PART_CODE), .SILICON_REVISION(SILICON_REVISION)) u_chk (
    .CLK(CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .CMD_DONE(CMD_DONE), .CMD_ABORT(CMD_ABORT),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .INTERNAL_REFERENCE_ENABLE(INTERNAL_REFERENCE_ENABLE),
    .CURRENT_SOURCE_ALLOW(CURRENT_SOURCE_ALLOW), .CONVERT_RESTART(CONVERT_RESTART), .DATA_READY_OUT(DATA_READY_OUT));

// >>> tb/acr_host_model.sv
// Host controller model issuing register commands
`timescale 1ns/10ps
module acr_host_model
    import acr_pkg::*;
(
    // Clock
    input wire logic clk,
    // Command lines
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    output logic done,
    output logic abort
);
    // ==========
    // Commands; fin 1 completes, 2 cuts short
    initial {addr, wdata, wr, rd, done, abort} = '0;
    task automatic wrc(input logic [7:0] a, input logic [7:0] d, input int fin);
        @(posedge clk);
        addr <= a;
        wdata <= a == ACR_OFS_POWER ? d & ACR_MASK_POWER : a == ACR_OFS_LINK ? d & ACR_MASK_LINK : d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~wdata; // Released lines toggle
        done <= fin == 1;
        abort <= fin == 2;
        @(posedge clk);
        {done, abort} <= 2'b00;
    endtask
    task automatic rdc(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
    endtask
endmodule // acr_host_model

// >>> tb/acr_regbank_tb.sv
// Self-checking bench for the control register bank
`timescale 1ns/10ps
module acr_regbank_tb;
    import acr_pkg::*;
    localparam logic [2:0] PC = 3'h3; // Arbitrary value
    localparam logic [4:0] SR = 5'h11; // Arbitrary value
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] a, wd, rdat, v;
    logic wr, rd, dn, ab, rv, ls, ir, cs, to, sb, rp, rs, rst, go, dr;
    logic [1:0] cm, ch;
    logic [3:0] sd;
    logic [7:0] exp_q [$];
    logic [31:0] lfsr = 32'h7F88;
    int bad_count = 0;
    int tests_run = 0;
    int n_rst = 0;
    int n;
    // ==========
    // Clock, partner and device
    always #10 clk = ~clk;
    acr_host_model host (.clk(clk), .addr(a), .wdata(wd), .wr(wr), .rd(rd), .done(dn), .abort(ab));
    acr_regbank #(.PART_CODE(PC), .SILICON_REVISION(SR)) DUT (.CLK(clk), .NRST(nrst), .REG_ADDR(a),
        .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .CMD_DONE(dn), .CMD_ABORT(ab), .REG_RDATA(rdat),
        .REG_RVALID(rv), .LEVEL_SHIFT_ENABLE(ls), .INTERNAL_REFERENCE_ENABLE(ir), .CURRENT_SOURCE_ALLOW(cs),
        .TIMEOUT_ENABLE(to), .STATUS_BYTE_ENABLE(sb), .CHECK_MODE(cm), .REFERENCE_POLARITY_INVERT(rp),
        .CONVERSION_RUN_SELECT(rs), .CHOP_MODE(ch), .START_DELAY(sd), .CONVERT_RESTART(rst), .CONVERT_GO(go),
        .DATA_READY_OUT(dr));
    // ==========
    // Helpers
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic rdx(input logic [7:0] ad, input logic [7:0] e);
        exp_q.push_back(e);
        host.rdc(ad);
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Read answers and restart pulses
    always @(negedge clk) begin
        if (rst === 1'b1) n_rst++;
        if (rv === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected read", 16'h0, 16'h1);
            else chk("read data", exp_q.pop_front(), rdat);
        end
    end
    // Watchdog
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end
    // ==========
    // Tests
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rdx(ACR_OFS_IDENTITY, {PC, SR});
        rdx(ACR_OFS_POWER, ACR_RST_POWER);
        rdx(ACR_OFS_LINK, ACR_RST_LINK);
        rdx(ACR_OFS_MODE, ACR_RST_MODE);
        rdx(8'h07, 8'h00);
        chk("reset outputs", 16'h6A01, {ls, ir, cs, to, sb, cm, rp, rs, ch, sd, dr});
        $display("Reset values done");
        host.wrc(ACR_OFS_IDENTITY, 8'hFF, 0);
        rdx(ACR_OFS_IDENTITY, {PC, SR});
        host.wrc(ACR_OFS_POWER, 8'h02, 0);
        rdx(ACR_OFS_POWER, 8'h02);
        wt(3);
        chk("power outputs", 16'h4, {ls, ir, cs});
        host.wrc(ACR_OFS_POWER, 8'h11, 0);
        rdx(ACR_OFS_POWER, 8'h01);
        $display("Power done");
        for (int c = 0; c < 3; c++) begin
            lfsr = nxt(lfsr);
            v = {4'h0, lfsr[1:0], 2'(c)};
            host.wrc(ACR_OFS_LINK, v, 0);
            rdx(ACR_OFS_LINK, v);
            wt(3);
            chk("link outputs", v, {to, sb, cm});
        end
        $display("Link done");
        for (int c = 0; c < 4; c++) begin
            lfsr = nxt(lfsr);
            v = {lfsr[1:0], 2'(c), 4'h0};
            host.wrc(ACR_OFS_MODE, v, 1);
            rdx(ACR_OFS_MODE, v);
            wt(3);
            chk("mode outputs", v, {rp, rs, ch, sd});
            chk("data ready", 16'h1, dr);
        end
        host.wrc(ACR_OFS_MODE, 8'h01, 1);
        for (n = 0; n < 20 && rst !== 1'b1; n++) @(negedge clk);
        for (n = 0; n < 5000 && go !== 1'b1; n++) @(negedge clk);
        // Count plus two register stages from restart pulse to go pulse
        chk("delay cycles", 16'(ACR_DELAY_NS[1] / ACR_CLK_NS + 2), 16'(n));
        host.wrc(ACR_OFS_MODE, 8'hC3, 2);
        rdx(ACR_OFS_MODE, 8'h01);
        wt(4);
        chk("restarts", 16'(n_rst), 16'd5);
        $display("Mode done");
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rdx(ACR_OFS_POWER, ACR_RST_POWER);
        wt(4);
        chk("pending reads", 16'(exp_q.size()), 16'h0);
        $display("Second reset done");
        wrap_up();
    end
endmodule // acr_regbank_tb
